// *** dev_model.sv ***
`timescale 1ns/10ps
`include "pulse_host_defs.svh"
// ------------------------------------------------
// timer device behind the byte port
// ------------------------------------------------
module dev_model (
  input  wire logic       aclk,
  input  wire logic       aresetn,
  input  wire logic       dev_we,
  input  wire logic [7:0] dev_addr,
  input  wire logic [7:0] dev_wdata,
  input  wire logic       external_count_input,
  output      logic       match_interrupt,
  output      logic       out_pin
);
  // lower_ctrl: [0] pulse gen, [1] external count, [2] warm-up
  logic [7:0]  lower_ctrl, upper_ctrl, sys_ctrl, port_latch;
  logic [15:0] width_buf, width_act, period, cnt, next_cnt;
  logic        ff, next_ff, cin_d, tick, hit_w, hit_p, run;

  assign run = upper_ctrl[3];
  assign out_pin = ~ff;

  // compare and count; warm-up never toggles the flop
  always_comb begin
    tick = run && (lower_ctrl[1] ? cin_d && !external_count_input
                                 : 1'b1);
    hit_w = tick && !lower_ctrl[2] && cnt == width_act;
    if (lower_ctrl[2]) begin
      hit_p = tick && cnt[15:8] == period[15:8];
    end else if (lower_ctrl[0]) begin
      hit_p = tick && cnt == period;
    end else begin
      hit_p = tick && cnt == 16'hffff;
    end
    next_ff = ff ^ ((hit_w ^ hit_p) && !lower_ctrl[2]);
    if (dev_we && dev_addr == `DEV_UPPER_CTRL && !run) begin
      next_ff = dev_wdata[7];
    end
    next_cnt = {cnt[15:8] + {7'h0, &cnt[7:0]}, cnt[7:0] + 8'h01};
    if (hit_p || !run) begin
      next_cnt = 16'h0000;
    end else if (!tick) begin
      next_cnt = cnt;
    end
  end

  // registers; width only buffered in pwm while running
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      {lower_ctrl, upper_ctrl, sys_ctrl, port_latch} <= 32'h0000_0000;
      {width_buf, width_act, period, cnt} <= 64'h0;
      ff <= 1'b0;
      cin_d <= 1'b1;
      match_interrupt <= 1'b0;
    end else begin
      ff <= next_ff;
      cnt <= next_cnt;
      cin_d <= external_count_input;
      match_interrupt <= hit_p;
      if (hit_p && !lower_ctrl[0]) width_act <= width_buf;
      if (dev_we) begin
        case (dev_addr)
          `DEV_LOWER_CTRL:  lower_ctrl <= dev_wdata;
          `DEV_UPPER_CTRL:  upper_ctrl <= dev_wdata;
          `DEV_WIDTH_LOW:   width_buf[7:0] <= dev_wdata;
          `DEV_WIDTH_HIGH:  width_buf[15:8] <= dev_wdata;
          `DEV_PERIOD_LOW:  period[7:0] <= dev_wdata;
          `DEV_PERIOD_HIGH: period[15:8] <= dev_wdata;
          `DEV_SYS_CTRL2:   sys_ctrl <= dev_wdata;
          default:          port_latch <= dev_wdata;
        endcase
        if (dev_addr == `DEV_WIDTH_HIGH && (!run || lower_ctrl[0])) begin
          width_act <= {dev_wdata, width_buf[7:0]};
        end
      end
    end
  end
endmodule

// *** pulse_host.sv ***
`timescale 1ns/10ps
`include "pulse_host_defs.svh"

// How it works
// - count input phases last two cycles minimum
// - width written low byte then high
// - width writes follow the match interrupt when the sync bit is set
// - stop first, change flop level afterwards
// - stop timer before oscillator stop mode
// - ppg registers unbuffered, unchanged while running
// - period and width written low then high
// - port latch set to one before output
// - warm-up keeps flop initial bit zero
// - slow warm-up sequence around match interrupt
// - fast warm-up sequence around match interrupt
module pulse_host #(
  parameter logic [15:0] min_phase_cycles = `EXT_MIN_PHASE_CYC
) (
  input  wire logic                 aclk,
  input  wire logic                 aresetn,
  input  wire logic                 awvalid,
  output      logic                 awready,
  input  wire logic [7:0]           awaddr,
  input  wire logic [2:0]           awprot,
  input  wire logic                 wvalid,
  output      logic                 wready,
  input  wire logic [31:0]          wdata,
  input  wire logic [3:0]           wstrb,
  output      logic                 bvalid,
  input  wire logic                 bready,
  output      logic [1:0]           bresp,
  input  wire logic                 arvalid,
  output      logic                 arready,
  input  wire logic [7:0]           araddr,
  input  wire logic [2:0]           arprot,
  output      logic                 rvalid,
  input  wire logic                 rready,
  output      logic [31:0]          rdata,
  output      logic [1:0]           rresp,
  output      logic                 dev_we,
  output      logic [7:0]           dev_addr,
  output      logic [7:0]           dev_wdata,
  input  wire logic                 match_interrupt,
  input  wire logic                 out_pin,
  output      logic                 external_count_input
);
  import pulse_host_pkg::*;

  // ------------------------------------------------------------------
  // state declarations
  // ------------------------------------------------------------------
  logic [31:0] data_reg, next_data_reg;
  logic [31:0] evt_reg, next_evt_reg;
  logic        next_awready, next_wready, next_bvalid;
  logic [1:0]  next_bresp, next_rresp;
  logic        next_arready, next_rvalid;
  logic [31:0] next_rdata;
  seq_state_e  state, next_state;
  op_e         op_q, next_op_q;
  logic [2:0]  step, next_step;
  logic [31:0] cmd_data, next_cmd_data;
  logic        sync_q, next_sync_q;
  logic        next_dev_we;
  logic [7:0]  next_dev_addr, next_dev_wdata;
  logic        match_q;
  logic [7:0]  match_cnt, next_match_cnt;
  logic [15:0] ev_cnt, next_ev_cnt;
  logic        next_ext;
  logic        pin_q;
  logic [15:0] run_cnt, next_run_cnt;
  logic [15:0] high_time, next_high_time;
  logic [15:0] low_time, next_low_time;

  logic        wr_fire, wr_mapped, cmd_go, cmd_abort, match_rise;
  logic [15:0] half_eff;
  step_s       cur;

  // ------------------------------------------------------------------
  // device write sequences
  // ------------------------------------------------------------------
  // each width and period value goes out as two byte writes, low byte first
  function automatic step_s step_f(input op_e op, input logic [2:0] idx,
                                   input logic [31:0] d, input logic sync);
    step_s s;
    s = '0;
    unique case (op)
      op_none: begin
        s.last = 1'b1;
      end
      op_width: begin
        s.addr = (idx == 3'd0) ? `DEV_WIDTH_LOW : `DEV_WIDTH_HIGH;
        s.wdata = (idx == 3'd0) ? d[7:0] : d[15:8];
        s.wait_match = (idx == 3'd0) && sync;
        s.last = (idx == 3'd1);
      end
      op_period: begin
        // only issued while the timer is stopped; no buffer behind it
        s.addr = (idx == 3'd0) ? `DEV_PERIOD_LOW : `DEV_PERIOD_HIGH;
        s.wdata = (idx == 3'd0) ? d[7:0] : d[15:8];
        s.last = (idx == 3'd1);
      end
      op_ctrl_low: begin
        s.addr = `DEV_LOWER_CTRL;
        s.wdata = d[7:0];
        s.last = 1'b1;
      end
      op_ctrl_high: begin
        s.addr = `DEV_UPPER_CTRL;
        s.wdata = d[7:0];
        s.last = 1'b1;
      end
      op_stop_level: begin
        // stop and level change never share one write
        s.addr = `DEV_UPPER_CTRL;
        s.wdata = ((idx == 3'd0) ? d[15:8] : d[7:0]) & ~`RUN_BIT_MASK;
        s.last = (idx == 3'd1);
      end
      op_port_latch: begin
        s.addr = `DEV_PORT_LATCH;
        s.wdata = d[7:0];
        s.last = 1'b1;
      end
      op_warmup: begin
        unique case (idx)
          3'd0: begin
            s.addr = `DEV_SYS_CTRL2; // oscillator on
            s.wdata = d[7:0];
          end
          3'd1: begin
            s.addr = `DEV_UPPER_CTRL; // start, initial bit low
            s.wdata = (d[15:8] | `RUN_BIT_MASK) & ~`FF_INIT_MASK;
          end
          3'd2: begin
            s.addr = `DEV_UPPER_CTRL; // stop after match
            s.wdata = d[15:8] & ~(`RUN_BIT_MASK | `FF_INIT_MASK);
            s.wait_match = 1'b1;
          end
          3'd3: begin
            s.addr = `DEV_SYS_CTRL2; // clock select
            s.wdata = d[23:16];
          end
          3'd4: begin
            s.addr = `DEV_SYS_CTRL2; // other oscillator off
            s.wdata = d[31:24];
            s.last = 1'b1;
          end
          default: begin
            s.last = 1'b1;
          end
        endcase
      end
    endcase
    return s;
  endfunction

  // byte-lane merge for strobed register writes
  function automatic logic [31:0] merge_f(input logic [31:0] old_v,
                                          input logic [31:0] new_v,
                                          input logic [3:0] strb);
    logic [31:0] r;
    r = old_v;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) begin
        r[8*i +: 8] = new_v[8*i +: 8];
      end
    end
    return r;
  endfunction

  // ------------------------------------------------------------------
  // axi4-lite write channel
  // ------------------------------------------------------------------
  // address and data are taken together; awvalid still holds at fire
  assign wr_fire = awready;
  assign wr_mapped = (awaddr == `OFS_CMD) || (awaddr == `OFS_DATA) ||
                     (awaddr == `OFS_EVT);
  assign cmd_go = wr_fire && (awaddr == `OFS_CMD) && wstrb[0] &&
                  (wdata[2:0] != 3'd0) && (state == st_idle);
  assign cmd_abort = wr_fire && (awaddr == `OFS_CMD) && wstrb[0] &&
                     (wdata[2:0] == 3'd0);

  always_comb begin
    next_awready = awvalid && wvalid && !awready && !bvalid;
    next_wready = next_awready;
    next_bvalid = bvalid;
    next_bresp = bresp;
    next_data_reg = data_reg;
    next_evt_reg = evt_reg;
    if (bvalid && bready) begin
      next_bvalid = 1'b0;
    end
    if (wr_fire) begin
      next_bvalid = 1'b1;
      next_bresp = wr_mapped ? 2'b00 : 2'b11;
      if (awaddr == `OFS_DATA) begin
        next_data_reg = merge_f(data_reg, wdata, wstrb);
      end
      if (awaddr == `OFS_EVT) begin
        next_evt_reg = merge_f(evt_reg, wdata, wstrb);
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      awready <= 1'b0;
      wready <= 1'b0;
      bvalid <= 1'b0;
      bresp <= 2'b00;
      data_reg <= `DATA_RESET;
      evt_reg <= `EVT_RESET;
    end else begin
      awready <= next_awready;
      wready <= next_wready;
      bvalid <= next_bvalid;
      bresp <= next_bresp;
      data_reg <= next_data_reg;
      evt_reg <= next_evt_reg;
    end
  end

  // ------------------------------------------------------------------
  // axi4-lite read channel
  // ------------------------------------------------------------------
  always_comb begin
    next_arready = arvalid && !arready && !rvalid;
    next_rvalid = rvalid;
    next_rdata = rdata;
    next_rresp = rresp;
    if (rvalid && rready) begin
      next_rvalid = 1'b0;
    end
    if (arready) begin
      next_rvalid = 1'b1;
      next_rresp = 2'b00;
      unique case (araddr)
        `OFS_CMD: next_rdata = {23'h0, sync_q, 5'h0, op_q};
        `OFS_DATA: next_rdata = data_reg;
        `OFS_EVT: next_rdata = evt_reg;
        // flop level is the inverse of the observed pin
        `OFS_STATUS: next_rdata = {16'h0, match_cnt, 4'h0, ~pin_q, pin_q,
                                   state == st_wait, state != st_idle};
        `OFS_MEAS: next_rdata = {low_time, high_time};
        default: begin
          next_rdata = 32'h0;
          next_rresp = 2'b11;
        end
      endcase
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      arready <= 1'b0;
      rvalid <= 1'b0;
      rdata <= 32'h0;
      rresp <= 2'b00;
    end else begin
      arready <= next_arready;
      rvalid <= next_rvalid;
      rdata <= next_rdata;
      rresp <= next_rresp;
    end
  end

  // ------------------------------------------------------------------
  // device write sequencer
  // ------------------------------------------------------------------
  // a command is ignored while busy; op zero aborts a pending wait
  assign match_rise = match_interrupt && !match_q;
  assign cur = step_f(op_q, step, cmd_data, sync_q);

  always_comb begin
    next_state = state;
    next_op_q = op_q;
    next_step = step;
    next_cmd_data = cmd_data;
    next_sync_q = sync_q;
    next_dev_we = 1'b0;
    next_dev_addr = dev_addr;
    next_dev_wdata = dev_wdata;
    next_match_cnt = match_rise ? 8'(match_cnt + 8'd1) : match_cnt;
    unique case (state)
      st_idle: begin
        if (cmd_go) begin
          next_op_q = op_e'(wdata[`CMD_OP_LSB +: 3]);
          next_sync_q = wdata[`CMD_SYNC_BIT];
          next_cmd_data = data_reg;
          next_step = 3'd0;
          next_state = st_issue;
        end
      end
      st_issue, st_wait: begin
        if (cmd_abort) begin
          next_state = st_idle;
        end else if (cur.wait_match && !(state == st_wait && match_rise)) begin
          next_state = st_wait; // write lands the cycle after match
        end else begin
          next_dev_we = 1'b1;
          next_dev_addr = cur.addr;
          next_dev_wdata = cur.wdata;
          next_step = 3'(step + 3'd1);
          next_state = cur.last ? st_idle : st_issue;
        end
      end
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state <= st_idle;
      op_q <= op_none;
      step <= 3'd0;
      cmd_data <= 32'h0;
      sync_q <= 1'b0;
      dev_we <= 1'b0;
      dev_addr <= 8'h00;
      dev_wdata <= 8'h00;
      match_q <= 1'b0;
      match_cnt <= 8'h00;
    end else begin
      state <= next_state;
      op_q <= next_op_q;
      step <= next_step;
      cmd_data <= next_cmd_data;
      sync_q <= next_sync_q;
      dev_we <= next_dev_we;
      dev_addr <= next_dev_addr;
      dev_wdata <= next_dev_wdata;
      match_q <= match_interrupt;
      match_cnt <= next_match_cnt;
    end
  end

  // ------------------------------------------------------------------
  // external count source
  // ------------------------------------------------------------------
  // the half period is clamped so no phase is ever too short; a disable
  // finishes the low phase first and then idles high
  assign half_eff = (evt_reg[31:16] < min_phase_cycles) ?
                    min_phase_cycles : evt_reg[31:16];

  always_comb begin
    next_ev_cnt = ev_cnt;
    next_ext = external_count_input;
    if (evt_reg[0] || !external_count_input) begin
      if (ev_cnt >= 16'(half_eff - 16'd1)) begin
        next_ev_cnt = 16'h0;
        next_ext = !external_count_input;
      end else begin
        next_ev_cnt = 16'(ev_cnt + 16'd1);
      end
    end else begin
      next_ev_cnt = 16'h0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ev_cnt <= 16'h0;
      external_count_input <= 1'b1;
    end else begin
      ev_cnt <= next_ev_cnt;
      external_count_input <= next_ext;
    end
  end

  // ------------------------------------------------------------------
  // output pin measurement
  // ------------------------------------------------------------------
  // counts saturate, so very long phases read as all ones
  always_comb begin
    next_run_cnt = (run_cnt == 16'hffff) ? run_cnt : 16'(run_cnt + 16'd1);
    next_high_time = high_time;
    next_low_time = low_time;
    if (out_pin != pin_q) begin
      next_run_cnt = 16'd1;
      if (pin_q) begin
        next_high_time = run_cnt;
      end else begin
        next_low_time = run_cnt;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pin_q <= 1'b0;
      run_cnt <= 16'h0;
      high_time <= 16'h0;
      low_time <= 16'h0;
    end else begin
      pin_q <= out_pin;
      run_cnt <= next_run_cnt;
      high_time <= next_high_time;
      low_time <= next_low_time;
    end
  end

endmodule

// *** pulse_host_assertions.sv ***
`timescale 1ns/10ps
`include "pulse_host_defs.svh"
// ----------------------------------------
// checks on the axi side, the byte port and the count input
// ----------------------------------------
module pulse_host_assertions #(
  parameter logic [15:0] min_phase_cycles = `EXT_MIN_PHASE_CYC
) (
  input wire logic       aclk,
  input wire logic       aresetn,
  input wire logic       awvalid,
  input wire logic       awready,
  input wire logic       wvalid,
  input wire logic       wready,
  input wire logic       bvalid,
  input wire logic       arvalid,
  input wire logic       arready,
  input wire logic       rvalid,
  input wire logic       dev_we,
  input wire logic [7:0] dev_addr,
  input wire logic [7:0] dev_wdata,
  input wire logic       external_count_input
);
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);

  // one upper control or system control byte write, and the bus offers
  sequence s_upper;
    dev_we && dev_addr == `DEV_UPPER_CTRL;
  endsequence
  sequence s_sys;
    dev_we && dev_addr == `DEV_SYS_CTRL2;
  endsequence
  sequence s_wr_offer;
    awvalid && wvalid && !awready && !bvalid;
  endsequence
  sequence s_rd_offer;
    arvalid && !arready && !rvalid;
  endsequence

  a_width_pair: assert property (
    dev_we && dev_addr == `DEV_WIDTH_LOW
    |=> dev_we && dev_addr == `DEV_WIDTH_HIGH)
    else $error("width high byte missing");
  a_period_pair: assert property (
    dev_we && dev_addr == `DEV_PERIOD_HIGH
    |-> $past(dev_we) && $past(dev_addr) == `DEV_PERIOD_LOW)
    else $error("period high byte without low byte");
  a_stop_then_level: assert property (
    s_upper ##1 s_upper |-> !dev_wdata[3] && !$past(dev_wdata[3]))
    else $error("level written while running");
  a_warmup_flop: assert property (
    s_sys ##1 s_upper |-> !dev_wdata[7] && dev_wdata[3])
    else $error("warm-up start with flop bit set");
  a_stop_first: assert property (
    s_upper ##1 s_sys |-> !$past(dev_wdata[3]))
    else $error("clock switched before stop");
  a_phase_min: assert property (
    $changed(external_count_input) |=> $stable(external_count_input))
    else $error("count input phase too short");
  a_write_answer: assert property (
    s_wr_offer |=> awready && wready ##1 bvalid)
    else $error("write not answered in time");
  a_read_answer: assert property (
    s_rd_offer |=> arready ##1 rvalid)
    else $error("read not answered in time");
endmodule

bind pulse_host pulse_host_assertions #(
  .min_phase_cycles(min_phase_cycles)
) pulse_host_assertions_inst (.*);

// *** pulse_host_defs.svh ***
`ifndef PULSE_HOST_DEFS_SVH
`define PULSE_HOST_DEFS_SVH

// --------------------------------------------------------------------
// controller register byte offsets on the axi4-lite side
// --------------------------------------------------------------------
`define OFS_CMD        8'h00
`define OFS_DATA       8'h04
`define OFS_EVT        8'h08
`define OFS_STATUS     8'h0c
`define OFS_MEAS       8'h10

// --------------------------------------------------------------------
// device register addresses on the device write port
// --------------------------------------------------------------------
`define DEV_LOWER_CTRL  8'h00
`define DEV_UPPER_CTRL  8'h01
`define DEV_WIDTH_LOW   8'h02
`define DEV_WIDTH_HIGH  8'h03
`define DEV_PERIOD_LOW  8'h04
`define DEV_PERIOD_HIGH 8'h05
`define DEV_SYS_CTRL2   8'h06
`define DEV_PORT_LATCH  8'h07

// --------------------------------------------------------------------
// upper timer control fields
// --------------------------------------------------------------------
`define RUN_BIT_MASK   8'h08
`define FF_INIT_MASK   8'h80

// --------------------------------------------------------------------
// command register fields
// --------------------------------------------------------------------
`define CMD_OP_LSB     0
`define CMD_SYNC_BIT   8

// --------------------------------------------------------------------
// timing counts, in aclk cycles
// --------------------------------------------------------------------
`define EXT_MIN_PHASE_CYC 16'd2

// --------------------------------------------------------------------
// reset values
// --------------------------------------------------------------------
`define EVT_RESET      32'h0000_0000
`define DATA_RESET     32'h0000_0000

`endif

// *** pulse_host_pkg.sv ***
package pulse_host_pkg;

  // operations the host sequencer can run against the device
  typedef enum logic [2:0] {
    op_none,
    op_width,
    op_period,
    op_ctrl_low,
    op_ctrl_high,
    op_stop_level,
    op_port_latch,
    op_warmup
  } op_e;

  typedef enum logic [1:0] {
    st_idle,
    st_issue,
    st_wait
  } seq_state_e;

  // one device byte write of a sequence
  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wdata;
    logic       wait_match;
    logic       last;
  } step_s;

endpackage

// *** tb_top.sv ***
`timescale 1ns/10ps
`include "pulse_host_defs.svh"
module tb_top;
  import pulse_host_pkg::*;
  logic        aclk = 1'b0;
  logic        aresetn = 1'b0;
  logic        awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
  logic        arvalid = 1'b0, rready = 1'b0;
  logic [7:0]  awaddr = 8'h00, araddr = 8'h00;
  logic [31:0] wdata = 32'h0000_0000;
  logic [2:0]  awprot = 3'h0, arprot = 3'h0;
  logic [3:0]  wstrb = 4'hf;
  logic        awready, wready, bvalid, arready, rvalid, dev_we;
  logic        match_interrupt, out_pin, external_count_input;
  logic [1:0]  bresp, rresp, rs;
  logic [31:0] rdata, rd, c0;
  logic [7:0]  dev_addr, dev_wdata;
  int          n_mismatch = 0;
  int          num_checks = 0;
  logic [31:0] warm_cfg [2] = '{32'h0607_8803, 32'h0203_0807};

  always #50 aclk = ~aclk;

  pulse_host pulse_host_inst (.*);
  dev_model dev_model_inst (.*);

  // ------------------------------
  // compare, bus and command tasks
  // ------------------------------
  task automatic chk_word(input string nm, input logic [31:0] e, g);
    num_checks++;
    if (g !== e) begin
      n_mismatch++;
      $display("[ERR] %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic chk_resp(input string nm, input logic [1:0] e, g);
    chk_word(nm, {30'h0, e}, {30'h0, g});
  endtask

  // each transfer starts one edge later, so no signal is set twice
  task automatic axi_write(input logic [7:0] a, input logic [31:0] d,
                           output logic [1:0] r);
    @(posedge aclk);
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    awaddr <= a;
    wdata <= d;
    bready <= 1'b1;
    do begin
      @(posedge aclk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
    end while (!bvalid);
    r = bresp;
    bready <= 1'b0;
  endtask

  task automatic axi_read(input logic [7:0] a, output logic [31:0] d,
                          output logic [1:0] r);
    @(posedge aclk);
    arvalid <= 1'b1;
    araddr <= a;
    rready <= 1'b1;
    do begin
      @(posedge aclk);
      if (arready) arvalid <= 1'b0;
    end while (!rvalid);
    d = rdata;
    r = rresp;
    rready <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    axi_write(a, d, rs);
    chk_resp("bresp", 2'b00, rs);
  endtask

  task automatic rd_chk(input logic [7:0] a, input logic [31:0] m, e,
                        input string nm);
    axi_read(a, rd, rs);
    chk_word(nm, e, rd & m);
  endtask

  // polling is bounded; a long pwm period needs many reads
  task automatic wait_idle;
    int k;
    k = 0;
    do begin
      axi_read(`OFS_STATUS, rd, rs);
      k++;
    end while (rd[0] !== 1'b0 && k < 20000);
    chk_word("idle", 32'h0, {31'h0, rd[0]});
  endtask

  task automatic cmd(input op_e op, input logic [31:0] d);
    wr(`OFS_DATA, d);
    wr(`OFS_CMD, {29'h0, op});
    wait_idle;
  endtask

  task automatic report_and_stop;
    if (n_mismatch == 0 && num_checks > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  // cut a hang short; the pwm overflow alone takes 65536 cycles
  initial begin
    repeat (95000) @(posedge aclk);
    n_mismatch++;
    report_and_stop;
  end

  // --------------
  // test sequence
  // --------------
  initial begin
    repeat (3) @(posedge aclk);
    aresetn <= 1'b1;
    rd_chk(`OFS_DATA, 32'hffff_ffff, `DATA_RESET, "data");
    rd_chk(`OFS_EVT, 32'hffff_ffff, `EVT_RESET, "evt");
    rd_chk(`OFS_STATUS, 32'hffff_ffff, 32'h4, "status");
    axi_read(8'h20, rd, rs);
    chk_resp("rresp", 2'b11, rs);
    axi_write(8'h20, 32'h1, rs);
    chk_resp("bresp", 2'b11, rs);
    cmd(op_port_latch, 32'h1);
    chk_word("latch", 32'h1, {24'h0, dev_model_inst.port_latch});
    // pulse generator: width 3, period 8
    cmd(op_width, 32'h3);
    cmd(op_period, 32'h8);
    chk_word("period", 32'h8, {16'h0, dev_model_inst.period});
    chk_word("width", 32'h3, {16'h0, dev_model_inst.width_act});
    cmd(op_ctrl_low, 32'h1);
    cmd(op_ctrl_high, 32'h8);
    repeat (40) @(posedge aclk);
    rd_chk(`OFS_MEAS, 32'hffff_ffff, 32'h0005_0004, "ppg");
    cmd(op_stop_level, 32'h80);
    chk_word("upper", 32'h80, {24'h0, dev_model_inst.upper_ctrl});
    rd_chk(`OFS_STATUS, 32'hf, 32'h8, "level");
    // pwm: width written stopped, then once more in sync with the match
    cmd(op_width, 32'h2);
    chk_word("act", 32'h2, {16'h0, dev_model_inst.width_act});
    cmd(op_ctrl_low, 32'h0);
    cmd(op_ctrl_high, 32'h8);
    axi_read(`OFS_STATUS, c0, rs);
    wr(`OFS_DATA, 32'h5);
    wr(`OFS_CMD, 32'h101);
    rd_chk(`OFS_STATUS, 32'h3, 32'h3, "waiting");
    wait_idle;
    chk_word("buf", 32'h5, {16'h0, dev_model_inst.width_buf});
    chk_word("act", 32'h2, {16'h0, dev_model_inst.width_act});
    rd_chk(`OFS_STATUS, 32'hff00, {16'h0, c0[15:8] + 8'h01, 8'h0},
           "matches");
    rd_chk(`OFS_MEAS, 32'hffff_ffff, 32'hfffd_0003, "pwm");
    cmd(op_stop_level, 32'h0);
    // a synced write while stopped never sees a match; op zero drops it
    wr(`OFS_CMD, 32'h101);
    rd_chk(`OFS_STATUS, 32'h3, 32'h3, "stuck");
    rd_chk(`OFS_CMD, 32'hffff_ffff, 32'h101, "cmd");
    wr(`OFS_CMD, 32'h0);
    rd_chk(`OFS_STATUS, 32'h3, 32'h0, "abort");
    chk_word("buf", 32'h5, {16'h0, dev_model_inst.width_buf});
    // warm-up, slow then fast clock
    cmd(op_period, 32'h1ff);
    cmd(op_ctrl_low, 32'h4);
    foreach (warm_cfg[i]) begin
      cmd(op_warmup, warm_cfg[i]);
      chk_word("sys", {24'h0, warm_cfg[i][31:24]},
               {24'h0, dev_model_inst.sys_ctrl});
      chk_word("upper", 32'h0,
               {24'h0, dev_model_inst.upper_ctrl});
    end
    // external count, three cycles a phase
    cmd(op_width, 32'h1);
    cmd(op_period, 32'h2);
    cmd(op_ctrl_low, 32'h3);
    wr(`OFS_EVT, 32'h0003_0001);
    cmd(op_ctrl_high, 32'h8);
    repeat (200) @(posedge aclk);
    rd_chk(`OFS_MEAS, 32'hffff_ffff, 32'h0006_000c, "ext");
    cmd(op_stop_level, 32'h0);
    wr(`OFS_EVT, 32'h0);
    report_and_stop;
  end
endmodule
